// file: inc/rsi_pkg.sv
// constants shared by the reset, stop and interrupt sequencer
// Function
// - after reset release the core reset is held two more periods, plus lock time with pll on.
// - handler execution starts no sooner than ten periods after the trigger.
// - stop exit with pll running needs irq a held 128k periods, or 25 with stop delay off.
// - with the pll stopped the required hold grows by the lock time.
// - with pll on and keep bit 12 clear the pll is shut in stop and relocked on exit.
// - with pll off bit 13 clear stop exit adds no stabilisation delay.
// - the output changed by the first handler instruction is valid within ten periods.
package rsi_pkg;
	localparam int CLK_HZ          = 10_000_000;
	localparam int CLK_NS          = 1_000_000_000 / CLK_HZ;
	localparam int RST_HOLD_CYC    = 2;
	localparam int EDGE_MIN_CYC    = 2;
	localparam int HANDLER_CYC     = 10;
	localparam int STOP_LONG_CYC   = 131072;
	localparam int STOP_SHORT_CYC  = 25;
	localparam int LOCK_US         = 500;
	localparam int LOCK_CYC        = (LOCK_US * 1000) / CLK_NS;
	localparam int CNT_W           = 20;
	// register offsets (axi4-lite byte addresses)
	localparam logic [7:0] ADDR_CTRL   = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_IRQ_ST = 8'h08;
	localparam logic [7:0] ADDR_IRQ_MK = 8'h0c;
	localparam logic [7:0] ADDR_GPO    = 8'h10;
	// control fields
	localparam int CTRL_STOP_DLY_OFF = 6;
	localparam int CTRL_PLL_KEEP     = 12;
	localparam int CTRL_PLL_EN       = 13;
	localparam int CTRL_EDGE_MODE    = 16;
	localparam int CTRL_STOP_REQ     = 20;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	// interrupt status bits
	localparam int EV_IRQ   = 0;
	localparam int EV_WAKE  = 1;
	localparam int EV_RUN   = 2;
	localparam int EV_W     = 3;
	typedef enum logic [2:0] {S_RESET, S_LOCK, S_RUN, S_STOP, S_WAKE, S_RELOCK} seq_e;
endpackage

// file: verilog/reset_stop_irq_sequencer.sv
// The register offsets and the AXI4-Lite register port were decided locally.
`timescale 1ns/1ns
// reset, stop and external interrupt sequencer with an axi4-lite register slave
module reset_stop_irq_sequencer #(
	parameter int LOCK_CYCLES = rsi_pkg::LOCK_CYC,
	parameter int STOP_LONG   = rsi_pkg::STOP_LONG_CYC
) (
	input  wire logic        clk,
	input  wire logic        reset,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        ext_irq_a_line,
	output logic             core_reset,
	output logic             pll_run,
	output logic             handler_start,
	output logic             gpo,
	output logic             irq
);
	import rsi_pkg::*;

	seq_e               state;
	logic [CNT_W-1:0]   cnt;
	logic [31:0]        ctrl;
	logic [EV_W-1:0]    ev_st;
	logic [EV_W-1:0]    ev_mk;
	logic               gpo_pend;
	logic               gpo_val;
	logic [2:0]         irq_sync;
	logic               irq_lvl;
	logic               irq_lvl_d;
	logic [CNT_W-1:0]   hold_cnt;
	logic [3:0]         hand_cnt;
	logic               hand_busy;
	logic               aw_held;
	logic               w_held;
	logic [7:0]         aw_addr;
	logic [31:0]        w_data;
	logic [3:0]         w_strb;
	logic               wr_fire;
	logic               clr_stop;
	logic [EV_W-1:0]    ev_set;
	logic [EV_W-1:0]    ev_clr;
	logic               edge_seen;
	logic [CNT_W-1:0]   wake_need;

	// pin synchroniser; a change counts once stages two and three agree
	always_ff @(posedge clk) begin
		if (reset) begin
			irq_sync <= 3'h0;
		end else begin
			irq_sync <= {irq_sync[1:0], ext_irq_a_line};
		end
	end

	// filtered level, only updated when the two late stages agree
	always_ff @(posedge clk) begin
		if (reset) begin
			irq_lvl   <= 1'b0;
			irq_lvl_d <= 1'b0;
		end else begin
			if (irq_sync[1] == irq_sync[2]) begin
				irq_lvl <= irq_sync[2];
			end
			irq_lvl_d <= irq_lvl;
		end
	end

	// an edge request must stay high two periods; short glitches are dropped
	always_ff @(posedge clk) begin
		if (reset) begin
			hold_cnt <= '0;
		end else if (!irq_lvl) begin
			hold_cnt <= '0;
		end else if (hold_cnt != {CNT_W{1'b1}}) begin
			hold_cnt <= hold_cnt + CNT_W'(1);
		end
	end

	assign edge_seen = irq_lvl && hold_cnt == CNT_W'(EDGE_MIN_CYC - 1);

	// stop exit hold time: long or short, plus lock time when the pll was shut
	always_comb begin
		wake_need = ctrl[CTRL_STOP_DLY_OFF] ? CNT_W'(STOP_SHORT_CYC) : CNT_W'(STOP_LONG);
		if (ctrl[CTRL_PLL_EN] && !ctrl[CTRL_PLL_KEEP]) begin
			wake_need = wake_need + CNT_W'(LOCK_CYCLES);
		end
	end

	assign clr_stop = state == S_STOP;

	// main sequencer for reset release, stop entry and stop recovery
	always_ff @(posedge clk) begin
		if (reset) begin
			state <= S_RESET;
			cnt   <= '0;
		end else begin
			case (state)
				S_RESET: begin
					// two periods of core reset after release, lock wait if pll on
					if (cnt == CNT_W'(RST_HOLD_CYC - 1)) begin
						cnt   <= '0;
						state <= ctrl[CTRL_PLL_EN] ? S_LOCK : S_RUN;
					end else begin
						cnt <= cnt + CNT_W'(1);
					end
				end
				S_LOCK: begin
					if (cnt == CNT_W'(LOCK_CYCLES - 1)) begin
						cnt   <= '0;
						state <= S_RUN;
					end else begin
						cnt <= cnt + CNT_W'(1);
					end
				end
				S_RUN: begin
					cnt <= '0;
					if (ctrl[CTRL_STOP_REQ]) begin
						state <= S_STOP;
					end
				end
				S_STOP: begin
					// level line counted from its first sampled high
					if (irq_lvl) begin
						state <= S_WAKE;
						cnt   <= CNT_W'(1);
					end
				end
				S_WAKE: begin
					// the line must stay high the whole hold; a drop returns to stop
					if (!irq_lvl) begin
						state <= S_STOP;
						cnt   <= '0;
					end else if (cnt >= wake_need) begin
						state <= S_RUN;
						cnt   <= '0;
					end else begin
						cnt <= cnt + CNT_W'(1);
					end
				end
				default: begin
					state <= S_RESET;
					cnt   <= '0;
				end
			endcase
		end
	end

	assign core_reset = state == S_RESET || state == S_LOCK;
	// pll shut in stop unless kept, and off whenever it is disabled
	assign pll_run = ctrl[CTRL_PLL_EN] &&
		!((state == S_STOP || state == S_WAKE) && !ctrl[CTRL_PLL_KEEP]);

	// handler launch: fixed ten-cycle latency from a trigger, one at a time
	always_ff @(posedge clk) begin
		if (reset) begin
			hand_cnt  <= 4'h0;
			hand_busy <= 1'b0;
		end else if (hand_busy) begin
			if (hand_cnt == 4'(HANDLER_CYC - 1)) begin
				hand_busy <= 1'b0;
				hand_cnt  <= 4'h0;
			end else begin
				hand_cnt <= hand_cnt + 4'h1;
			end
		end else if (state == S_RUN && edge_seen && ctrl[CTRL_EDGE_MODE]) begin
			hand_busy <= 1'b1;
		end else if (state == S_RUN && irq_lvl && !irq_lvl_d && !ctrl[CTRL_EDGE_MODE]) begin
			hand_busy <= 1'b1;
		end
	end

	assign handler_start = hand_busy && hand_cnt == 4'(HANDLER_CYC - 1);

	// software stages a value; the first handler instruction drives it out
	always_ff @(posedge clk) begin
		if (reset) begin
			gpo <= 1'b0;
		end else if (handler_start && gpo_pend) begin
			gpo <= gpo_val;
		end
	end

	// interrupt events: set wins over a write-one clear
	assign ev_set = {handler_start, (state == S_WAKE && cnt >= wake_need && irq_lvl),
		(state == S_RUN && (edge_seen || (irq_lvl && !irq_lvl_d)))};
	assign ev_clr = (wr_fire && aw_addr == ADDR_IRQ_ST) ? w_data[EV_W-1:0] : '0;

	always_ff @(posedge clk) begin
		if (reset) begin
			ev_st <= '0;
		end else begin
			ev_st <= (ev_st & ~ev_clr) | ev_set;
		end
	end

	assign irq = |(ev_st & ev_mk);

	// axi write channel capture, address and data in either order
	assign s_axi_awready = !aw_held && !s_axi_bvalid;
	assign s_axi_wready  = !w_held && !s_axi_bvalid;
	assign wr_fire       = aw_held && w_held && !s_axi_bvalid;

	always_ff @(posedge clk) begin
		if (reset) begin
			aw_held <= 1'b0;
			w_held  <= 1'b0;
			aw_addr <= 8'h00;
			w_data  <= 32'h0000_0000;
			w_strb  <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end else if (wr_fire) begin
				aw_held <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end else if (wr_fire) begin
				w_held <= 1'b0;
			end
		end
	end

	// register writes; stop request self-clears when stop is entered
	always_ff @(posedge clk) begin
		if (reset) begin
			ctrl     <= CTRL_RESET;
			ev_mk    <= '0;
			gpo_val  <= 1'b0;
			gpo_pend <= 1'b0;
		end else begin
			if (wr_fire && aw_addr == ADDR_CTRL) begin
				for (int i = 0; i < 4; i++) begin
					if (w_strb[i]) begin
						ctrl[i*8 +: 8] <= w_data[i*8 +: 8];
					end
				end
			end else if (clr_stop) begin
				ctrl[CTRL_STOP_REQ] <= 1'b0;
			end
			if (wr_fire && aw_addr == ADDR_IRQ_MK && w_strb[0]) begin
				ev_mk <= w_data[EV_W-1:0];
			end
			if (wr_fire && aw_addr == ADDR_GPO && w_strb[0]) begin
				gpo_val  <= w_data[0];
				gpo_pend <= 1'b1;
			end else if (handler_start) begin
				gpo_pend <= 1'b0;
			end
		end
	end

	// write response, slverr for unmapped offsets
	always_ff @(posedge clk) begin
		if (reset) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= 2'h0;
		end else if (wr_fire) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= (aw_addr == ADDR_CTRL || aw_addr == ADDR_IRQ_ST ||
				aw_addr == ADDR_IRQ_MK || aw_addr == ADDR_GPO) ? 2'h0 : 2'h2;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// read channel, one cycle to data
	assign s_axi_arready = !s_axi_rvalid;

	always_ff @(posedge clk) begin
		if (reset) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= 2'h0;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp  <= 2'h0;
			case (s_axi_araddr)
				ADDR_CTRL:   s_axi_rdata <= ctrl;
				ADDR_STATUS: s_axi_rdata <= {24'h0, gpo, pll_run, core_reset, hand_busy,
					irq_lvl, state};
				ADDR_IRQ_ST: s_axi_rdata <= {29'h0, ev_st};
				ADDR_IRQ_MK: s_axi_rdata <= {29'h0, ev_mk};
				ADDR_GPO:    s_axi_rdata <= {30'h0, gpo_pend, gpo_val};
				default: begin
					s_axi_rdata <= 32'h0000_0000;
					s_axi_rresp <= 2'h2;
				end
			endcase
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// nine quiet cycles after the launch is first seen; repetition kept short for the tools
	sequence hand_quiet;
		!handler_start [*8] ##1 !handler_start;
	endsequence

	// handler start lands exactly nine cycles after the launch, ten after the trigger
	chk_handler_latency: assert property (@(posedge clk) disable iff (reset)
		$rose(hand_busy) |-> hand_quiet ##1 handler_start)
		else $error("handler start not ten cycles after trigger");

	// core reset stays asserted two cycles after release
	chk_reset_hold: assert property (@(posedge clk) $fell(reset) |-> core_reset [*2])
		else $error("core reset released too early");

	// in edge mode, short glitches never launch a handler
	chk_edge_width: assert property (@(posedge clk) disable iff (reset)
		$rose(hand_busy) && ctrl[CTRL_EDGE_MODE] |-> $past(irq_lvl, 2))
		else $error("edge request accepted below two cycles");

	// stop exit only after the full hold
	chk_wake_hold: assert property (@(posedge clk) disable iff (reset)
		$past(state) == S_WAKE && state == S_RUN |-> $past(cnt) >= $past(wake_need))
		else $error("stop exit before hold completed");

	// pll shut while stopped unless kept
	chk_pll_stop: assert property (@(posedge clk) disable iff (reset)
		state == S_STOP && !ctrl[CTRL_PLL_KEEP] |-> !pll_run)
		else $error("pll running in stop");

	// lock time added only when the pll is shut
	chk_no_stab: assert property (@(posedge clk) disable iff (reset)
		!ctrl[CTRL_PLL_EN] |-> wake_need <= CNT_W'(STOP_LONG))
		else $error("stabilisation delay added with pll off");

	chk_lock_add: assert property (@(posedge clk) disable iff (reset)
		ctrl[CTRL_PLL_EN] && !ctrl[CTRL_PLL_KEEP] |-> wake_need >= CNT_W'(LOCK_CYCLES))
		else $error("lock time missing from stop exit");

	// staged output appears on the handler start edge
	chk_gpo_valid: assert property (@(posedge clk) disable iff (reset)
		handler_start && gpo_pend |=> gpo == $past(gpo_val))
		else $error("output not valid after first handler instruction");
endmodule

// file: dv/irq_source.sv
`timescale 1ns/1ns
// model of the external interrupt line a driver on the board side
module irq_source (
	input  wire logic clk,
	output logic      line
);
	import rsi_pkg::*;

	// line idles low until a request is made
	initial line = 1'b0;

	// one request: high for n cycles, never shorter than the edge minimum
	task automatic hold(input int n);
		int w;
		w = (n < EDGE_MIN_CYC) ? EDGE_MIN_CYC : n;
		@(posedge clk);
		line <= 1'b1;
		repeat (w) @(posedge clk);
		line <= 1'b0;
		// quiet gap keeps requests under the rate limits and apart
		repeat (12) @(posedge clk);
	endtask
endmodule

// file: dv/test_reset_stop_irq_sequencer.sv
`timescale 1ns/1ns
// self-checking bench for the reset, stop and interrupt sequencer
module test_reset_stop_irq_sequencer;
	import rsi_pkg::*;
	localparam int          LOCK    = 4;
	localparam int          LONG    = 40;
	localparam logic [31:0] DLY_OFF = 32'h1 << CTRL_STOP_DLY_OFF;
	localparam logic [31:0] KEEP    = 32'h1 << CTRL_PLL_KEEP;
	localparam logic [31:0] PEN     = 32'h1 << CTRL_PLL_EN;
	localparam logic [31:0] EDGE    = 32'h1 << CTRL_EDGE_MODE;
	localparam logic [31:0] STOP    = 32'h1 << CTRL_STOP_REQ;
	logic        clk     = 1'b0;
	logic        reset   = 1'b1;
	logic [7:0]  awaddr  = 8'h00;
	logic [7:0]  araddr  = 8'h00;
	logic [31:0] wdata   = 32'h0;
	logic [3:0]  wstrb   = 4'hf;
	logic        awvalid = 1'b0;
	logic        wvalid  = 1'b0;
	logic        bready  = 1'b0;
	logic        arvalid = 1'b0;
	logic        rready  = 1'b0;
	logic        awready, wready, bvalid, arready, rvalid, line;
	logic        core_reset, pll_run, handler_start, gpo, irq;
	logic [1:0]  bresp, rresp;
	logic [31:0] rdata;
	int          error_cnt = 0;
	int          checks    = 0;
	int          cyc       = 0;

	// 100 ns clock
	always #50 clk = ~clk;

	reset_stop_irq_sequencer #(.LOCK_CYCLES(LOCK), .STOP_LONG(LONG)) DUT (
		.clk(clk), .reset(reset), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.ext_irq_a_line(line), .core_reset(core_reset), .pll_run(pll_run),
		.handler_start(handler_start), .gpo(gpo), .irq(irq)
	);
	irq_source src (.clk(clk), .line(line));

	task automatic chk(input string n, input logic [33:0] seen, input logic [33:0] exp);
		checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", n, exp, seen);
		end
	endtask

	task automatic finish_test();
		if (error_cnt == 0 && checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// hang guard, far above the fewer than a thousand cycles the run needs
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			error_cnt++;
			finish_test();
		end
	end

	// one axi4-lite transfer; handshakes are judged at the negedge before the
	// taking edge so that the release after that edge never races the slave
	task automatic bus(input bit w, input logic [7:0] a, input logic [31:0] d,
			output logic [31:0] q, output logic [1:0] r);
		logic ha, hw, hr, fin;
		fin = 1'b0;
		@(posedge clk);
		awaddr  <= a;
		araddr  <= a;
		wdata   <= d;
		awvalid <= w;
		wvalid  <= w;
		bready  <= w;
		arvalid <= !w;
		rready  <= !w;
		while (!fin) begin
			@(negedge clk);
			ha  = awvalid & awready;
			hw  = wvalid & wready;
			hr  = arvalid & arready;
			fin = w ? bvalid : rvalid;
			q   = rdata;
			r   = w ? bresp : rresp;
			@(posedge clk);
			if (ha) awvalid <= 1'b0;
			if (hw) wvalid <= 1'b0;
			if (hr) arvalid <= 1'b0;
		end
		bready <= 1'b0;
		rready <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic [1:0]  r;
		bus(1'b1, a, d, q, r);
		chk("write resp", r, 2'h0);
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] q);
		logic [1:0] r;
		bus(1'b0, a, 32'h0, q, r);
		chk("read resp", r, 2'h0);
	endtask

	// trigger to handler latency, staged output, status, mask and clear
	task automatic t_handler(input logic [31:0] m);
		logic [31:0] q;
		logic        v;
		int          n;
		n = 0;
		v = (m != 32'h0);
		wr(ADDR_CTRL, m);
		wr(ADDR_IRQ_MK, 32'h7);
		wr(ADDR_GPO, {31'h0, v});
		fork
			src.hold(4);
		join_none
		do begin
			@(negedge clk);
			n++;
		end while (handler_start !== 1'b1 && n < 40);
		chk("handler delay", n > HANDLER_CYC && n <= 20, 1'b1);
		@(negedge clk);
		chk("gpo value", gpo, v);
		wait fork;
		rd(ADDR_IRQ_ST, q);
		chk("irq status", q & 32'h5, 32'h5);
		chk("irq level", irq, 1'b1);
		wr(ADDR_IRQ_ST, 32'h7);
		chk("irq cleared", irq, 1'b0);
		wr(ADDR_IRQ_MK, 32'h0);
		src.hold(4);
		rd(ADDR_IRQ_ST, q);
		chk("masked status", q[EV_IRQ], 1'b1);
		chk("masked irq", irq, 1'b0);
		wr(ADDR_IRQ_ST, 32'h7);
	endtask

	// stop entry, a too short wake attempt, then a long enough one
	task automatic t_stop(input logic [31:0] c, input int need, input logic p);
		logic [31:0] q;
		wr(ADDR_CTRL, c);
		repeat (10) @(posedge clk);
		wr(ADDR_CTRL, c | STOP);
		rd(ADDR_STATUS, q);
		chk("stop entered", q[2:0], S_STOP);
		chk("pll in stop", pll_run, p);
		src.hold(need - 3);
		rd(ADDR_STATUS, q);
		chk("early wake", q[2:0], S_STOP);
		src.hold(need + 2);
		rd(ADDR_STATUS, q);
		chk("woken", q[2:0], S_RUN);
		chk("pll after wake", pll_run, c[CTRL_PLL_EN]);
		rd(ADDR_IRQ_ST, q);
		chk("wake event", q[EV_WAKE], 1'b1);
		wr(ADDR_IRQ_ST, 32'h7);
	endtask

	// main sequence
	initial begin
		logic [31:0] q;
		logic [1:0]  r;
		repeat (20) @(posedge clk);
		reset <= 1'b0;
		repeat (2) begin
			@(negedge clk);
			chk("core_reset held", core_reset, 1'b1);
		end
		repeat (3) @(negedge clk);
		chk("core_reset released", core_reset, 1'b0);
		chk("idle outputs", {pll_run, gpo, irq}, 3'h0);
		rd(ADDR_CTRL, q);
		chk("ctrl reset", q, CTRL_RESET);
		// only the strobed byte of the control word may change
		wstrb <= 4'h1;
		wr(ADDR_CTRL, 32'hffff_ffff);
		wstrb <= 4'hf;
		rd(ADDR_CTRL, q);
		chk("ctrl byte strobe", q, 32'h0000_00ff);
		bus(1'b0, 8'h3c, 32'h0, q, r);
		chk("unmapped read", {r, q}, {2'h2, 32'h0});
		bus(1'b1, 8'h3c, 32'h0, q, r);
		chk("unmapped write", r, 2'h2);
		t_handler(EDGE);
		t_handler(32'h0);
		t_stop(DLY_OFF, STOP_SHORT_CYC, 1'b0);
		t_stop(32'h0, LONG, 1'b0);
		t_stop(PEN | DLY_OFF, STOP_SHORT_CYC + LOCK, 1'b0);
		t_stop(PEN | KEEP | DLY_OFF, STOP_SHORT_CYC, 1'b1);
		t_stop(PEN, LONG + LOCK, 1'b0);
		finish_test();
	end
endmodule
